// file: hdl/lscr_regs.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`include "lscr_defines.svh"
// How it works
// - Once the index strap decode is latched, the index-done bit is set.
// - The latched index strap code reads in bits 6 to 4 of strap status.
// - Once the mode strap decode is latched, the mode-done bit is set.
// - The latched mode strap code reads in bits 2 to 0 of strap status.
// - With the ignore bit set, errors in the post-filter wait are dropped.
// - Link errors count only while the enable bit, reset to 1, is set.
// - With counting on, lock drops once the count reaches the threshold.
// - With counting off, lock drops on the first link error.
// - Parity, clock and control faults on the pixel clock count as errors.
// - With encoder CRC on, reset 1, failing packets leave info unchanged.
// - In raw mode frame start waits for frame valid held min-time clocks.
// - A pulldown-disable bit keeps that pin's pulldown off in all modes.
module lscr_regs #(
    parameter int PADDR_W = 12,
    parameter int GPIO_N = 7,
    parameter int STRAP_SETTLE_CYCLES =
        (`LSCR_STRAP_SETTLE_NS + `LSCR_CLK_PERIOD_NS - 1) /
        `LSCR_CLK_PERIOD_NS,
    parameter int FILTER_WAIT_CYCLES =
        (`LSCR_FILTER_WAIT_NS + `LSCR_CLK_PERIOD_NS - 1) /
        `LSCR_CLK_PERIOD_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [2:0] strap_index_pin,
    input wire logic [2:0] strap_mode_pin,
    input wire logic lock_acquired,
    input wire logic filter_update,
    input wire logic parity_error,
    input wire logic clock_error,
    input wire logic control_error,
    output logic rx_lock,
    input wire logic pkt_valid,
    input wire logic pkt_crc_ok,
    input wire logic [7:0] pkt_info,
    output logic [7:0] link_info,
    input wire logic raw_mode,
    input wire logic frame_active_flag,
    output logic frame_start,
    input wire logic [GPIO_N-1:0] gpio_output_mode,
    output logic [GPIO_N-1:0] gpio_pulldown_en
);

    if (PADDR_W < 10) begin : g_chk_addr
        $error("PADDR_W too small for register map");
    end
    if (GPIO_N != 7) begin : g_chk_gpio
        $error("GPIO_N must be 7");
    end
    if (STRAP_SETTLE_CYCLES < 1 || STRAP_SETTLE_CYCLES > 255) begin : g_chk_s
        $error("STRAP_SETTLE_CYCLES out of range");
    end
    if (FILTER_WAIT_CYCLES < 1 || FILTER_WAIT_CYCLES > 255) begin : g_chk_f
        $error("FILTER_WAIT_CYCLES out of range");
    end

    localparam logic [7:0] SETTLE_LAST = 8'(STRAP_SETTLE_CYCLES - 1);
    localparam logic [7:0] FWAIT_LOAD = 8'(FILTER_WAIT_CYCLES);

    function automatic logic [PADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = PADDR_W'({idx, 2'b00});
    endfunction : reg_addr

    // Register storage
    lscr_pkg::lscr_byte_t rsvd_b6;
    lscr_pkg::lscr_byte_t rsvd_b7;
    lscr_pkg::lscr_byte_t rsvd_bb;
    lscr_pkg::lscr_byte_t rsvd_bd;
    lscr_pkg::lscr_byte_t rsvd_bf;
    logic [5:0] errcnt_ctrl;
    lscr_pkg::lscr_byte_t encoder_crc_ctrl;
    lscr_pkg::lscr_byte_t frame_valid_min_time;
    logic [GPIO_N-1:0] gpio_pulldown_disable;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    lscr_pkg::lscr_byte_t strap_decode_status;

    // Bus decode
    logic access;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] next_prdata;
    assign access = psel & penable & pready;
    assign wr_en = access & pwrite;
    assign rd_en = access & ~pwrite;

    always_comb begin
        next_prdata = 32'h0;
        hit = 1'b1;
        case (paddr)
            reg_addr(`LSCR_IDX_RSVD_B6): next_prdata = {24'h0, rsvd_b6};
            reg_addr(`LSCR_IDX_RSVD_B7): next_prdata = {24'h0, rsvd_b7};
            reg_addr(`LSCR_IDX_STRAP):
                next_prdata = {24'h0, strap_decode_status};
            reg_addr(`LSCR_IDX_ERRCNT): next_prdata = {26'h0, errcnt_ctrl};
            reg_addr(`LSCR_IDX_ENC): next_prdata = {24'h0, encoder_crc_ctrl};
            reg_addr(`LSCR_IDX_RSVD_BB): next_prdata = {24'h0, rsvd_bb};
            reg_addr(`LSCR_IDX_FVMIN):
                next_prdata = {24'h0, frame_valid_min_time};
            reg_addr(`LSCR_IDX_RSVD_BD): next_prdata = {24'h0, rsvd_bd};
            reg_addr(`LSCR_IDX_GPIO_PD):
                next_prdata = {25'h0, gpio_pulldown_disable};
            reg_addr(`LSCR_IDX_RSVD_BF): next_prdata = {24'h0, rsvd_bf};
            reg_addr(`LSCR_IDX_IRQ_STATUS): next_prdata = {28'h0, irq_status};
            reg_addr(`LSCR_IDX_IRQ_MASK): next_prdata = {28'h0, irq_mask};
            default: hit = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // Writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_b6 <= `LSCR_RST_RSVD_B6;
            rsvd_b7 <= `LSCR_RST_RSVD_B7;
            rsvd_bb <= `LSCR_RST_RSVD_BB;
            rsvd_bd <= `LSCR_RST_RSVD_BD;
            rsvd_bf <= `LSCR_RST_RSVD_BF;
            errcnt_ctrl <= `LSCR_RST_ERRCNT;
            encoder_crc_ctrl <= `LSCR_RST_ENC;
            frame_valid_min_time <= `LSCR_RST_FVMIN;
            gpio_pulldown_disable <= `LSCR_RST_GPIO_PD;
            irq_mask <= `LSCR_RST_IRQ_MASK;
        end else if (wr_en) begin
            case (paddr)
                reg_addr(`LSCR_IDX_RSVD_B6):
                    rsvd_b6 <= pwdata[7:0];
                reg_addr(`LSCR_IDX_RSVD_B7):
                    rsvd_b7 <= pwdata[7:0];
                reg_addr(`LSCR_IDX_RSVD_BB):
                    rsvd_bb <= pwdata[7:0];
                reg_addr(`LSCR_IDX_RSVD_BD):
                    rsvd_bd <= pwdata[7:0];
                reg_addr(`LSCR_IDX_RSVD_BF):
                    rsvd_bf <= pwdata[7:0];
                reg_addr(`LSCR_IDX_ERRCNT): errcnt_ctrl <= pwdata[5:0];
                reg_addr(`LSCR_IDX_ENC): encoder_crc_ctrl <= pwdata[7:0];
                reg_addr(`LSCR_IDX_FVMIN): frame_valid_min_time <= pwdata[7:0];
                reg_addr(`LSCR_IDX_GPIO_PD):
                    gpio_pulldown_disable <= pwdata[GPIO_N-1:0];
                reg_addr(`LSCR_IDX_IRQ_MASK): irq_mask <= pwdata[3:0];
                // Status, read-only and unmapped offsets ignore writes
                default: ;
            endcase
        end
    end

    // Strap pin synchronisers
    logic [2:0] idx_s1;
    logic [2:0] idx_s2;
    logic [2:0] idx_s3;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic [2:0] mode_s3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_s1 <= 3'h0;
            idx_s2 <= 3'h0;
            idx_s3 <= 3'h0;
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
            mode_s3 <= 3'h0;
        end else begin
            idx_s1 <= strap_index_pin;
            idx_s2 <= idx_s1;
            idx_s3 <= idx_s2;
            mode_s1 <= strap_mode_pin;
            mode_s2 <= mode_s1;
            mode_s3 <= mode_s2;
        end
    end

    // Strap decode: wait for the pins to hold steady, then latch once
    lscr_pkg::lscr_strap_e strap_state;
    logic [7:0] settle_cnt;
    logic straps_stable;
    logic strap_done_evt;
    assign straps_stable = (idx_s2 == idx_s3) && (mode_s2 == mode_s3);
    assign strap_done_evt = (strap_state == lscr_pkg::LSCR_ST_SETTLE) &&
        straps_stable && (settle_cnt == SETTLE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_state <= lscr_pkg::LSCR_ST_FILL;
            settle_cnt <= 8'h0;
        end else begin
            unique case (strap_state)
                lscr_pkg::LSCR_ST_FILL: begin
                    settle_cnt <= 8'h0;
                    strap_state <= lscr_pkg::LSCR_ST_SETTLE;
                end
                lscr_pkg::LSCR_ST_SETTLE: begin
                    if (!straps_stable) begin
                        settle_cnt <= 8'h0;
                    end else if (settle_cnt == SETTLE_LAST) begin
                        strap_state <= lscr_pkg::LSCR_ST_DONE;
                    end else begin
                        settle_cnt <= settle_cnt + 8'h1;
                    end
                end
                lscr_pkg::LSCR_ST_DONE: ;
                default: strap_state <= lscr_pkg::LSCR_ST_FILL;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_decode_status <= 8'h0;
        end else if (strap_done_evt) begin
            strap_decode_status[`LSCR_STRAP_IDX_HI:`LSCR_STRAP_IDX_LO] <=
                idx_s3;
            strap_decode_status[`LSCR_STRAP_INDEX_DECODE_COMPLETE] <= 1'b1;
            strap_decode_status[`LSCR_STRAP_MODE_HI:`LSCR_STRAP_MODE_LO] <=
                mode_s3;
            strap_decode_status[`LSCR_STRAP_MODE_DONE] <= 1'b1;
        end
    end

    // Link error monitor
    logic ignore_wait;
    logic count_en;
    logic [3:0] err_thresh;
    logic [7:0] fwait_cnt;
    logic [3:0] err_cnt;
    logic link_err;
    logic err_valid;
    logic lock_lost_evt;
    assign ignore_wait = errcnt_ctrl[`LSCR_ERR_IGNORE_BIT];
    assign count_en = errcnt_ctrl[`LSCR_ERR_EN_BIT];
    assign err_thresh = errcnt_ctrl[`LSCR_ERR_THR_HI:`LSCR_ERR_THR_LO];
    assign link_err = parity_error | clock_error | control_error;
    assign err_valid = link_err &
        ~(ignore_wait & (fwait_cnt != 8'h0));
    // Threshold 0 behaves as 1: the first counted error drops lock
    assign lock_lost_evt = rx_lock & err_valid &
        (~count_en | (err_cnt + 4'h1 >= err_thresh));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwait_cnt <= 8'h0;
        end else if (filter_update) begin
            fwait_cnt <= FWAIT_LOAD;
        end else if (fwait_cnt != 8'h0) begin
            fwait_cnt <= fwait_cnt - 8'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt <= 4'h0;
        end else if (lock_acquired || lock_lost_evt || !rx_lock) begin
            err_cnt <= 4'h0;
        end else if (count_en && err_valid) begin
            err_cnt <= err_cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_lock <= 1'b0;
        end else if (lock_lost_evt) begin
            rx_lock <= 1'b0;
        end else if (lock_acquired) begin
            rx_lock <= 1'b1;
        end
    end

    // Link information update with CRC filtering
    logic crc_reject_evt;
    assign crc_reject_evt = pkt_valid & ~pkt_crc_ok &
        encoder_crc_ctrl[`LSCR_ENC_CRC_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_info <= 8'h0;
        end else if (pkt_valid && !crc_reject_evt) begin
            link_info <= pkt_info;
        end
    end

    // Raw mode frame start after minimum frame valid time
    logic [7:0] fv_cnt;
    logic fv_fired;
    logic frame_start_evt;
    assign frame_start_evt = raw_mode & frame_active_flag & ~fv_fired &
        (fv_cnt >= frame_valid_min_time);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fv_cnt <= 8'h0;
            fv_fired <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            frame_start <= frame_start_evt;
            if (!raw_mode || !frame_active_flag) begin
                fv_cnt <= 8'h0;
                fv_fired <= 1'b0;
            end else begin
                // Saturate so a long frame valid cannot wrap and fire again
                if (fv_cnt != 8'hff) begin
                    fv_cnt <= fv_cnt + 8'h1;
                end
                if (frame_start_evt) begin
                    fv_fired <= 1'b1;
                end
            end
        end
    end

    // GPIO pulldown control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_pulldown_en <= '0;
        end else begin
            gpio_pulldown_en <= ~gpio_output_mode &
                ~gpio_pulldown_disable;
        end
    end

    // Interrupt status: set wins over read clear
    logic [3:0] irq_set;
    assign irq_set = {strap_done_evt, frame_start_evt, crc_reject_evt,
        lock_lost_evt};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 4'h0;
        end else if (rd_en && paddr == reg_addr(`LSCR_IDX_IRQ_STATUS)) begin
            irq_status <= irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            // Same-cycle events count so an interrupt is not a cycle late
            irq <= |((irq_status | irq_set) & irq_mask);
        end
    end

endmodule : lscr_regs

// file: hdl/lscr_defines.svh
`ifndef LSCR_DEFINES_SVH
`define LSCR_DEFINES_SVH

// Register indexes; byte address is four times the index
`define LSCR_IDX_RSVD_B6 8'hb6
`define LSCR_IDX_RSVD_B7 8'hb7
`define LSCR_IDX_STRAP 8'hb8
`define LSCR_IDX_ERRCNT 8'hb9
`define LSCR_IDX_ENC 8'hba
`define LSCR_IDX_RSVD_BB 8'hbb
`define LSCR_IDX_FVMIN 8'hbc
`define LSCR_IDX_RSVD_BD 8'hbd
`define LSCR_IDX_GPIO_PD 8'hbe
`define LSCR_IDX_RSVD_BF 8'hbf
`define LSCR_IDX_IRQ_STATUS 8'hc0
`define LSCR_IDX_IRQ_MASK 8'hc1

// Reset values
`define LSCR_RST_RSVD_B6 8'h18
`define LSCR_RST_RSVD_B7 8'h00
`define LSCR_RST_ERRCNT 6'h33
`define LSCR_RST_ENC 8'h83
`define LSCR_RST_RSVD_BB 8'h74
`define LSCR_RST_FVMIN 8'h80
`define LSCR_RST_RSVD_BD 8'h00
`define LSCR_RST_GPIO_PD 7'h00
`define LSCR_RST_RSVD_BF 8'h00
`define LSCR_RST_IRQ_MASK 4'h0

// Field positions
`define LSCR_STRAP_INDEX_DECODE_COMPLETE 7
`define LSCR_STRAP_IDX_HI 6
`define LSCR_STRAP_IDX_LO 4
`define LSCR_STRAP_MODE_DONE 3
`define LSCR_STRAP_MODE_HI 2
`define LSCR_STRAP_MODE_LO 0
`define LSCR_ERR_IGNORE_BIT 5
`define LSCR_ERR_EN_BIT 4
`define LSCR_ERR_THR_HI 3
`define LSCR_ERR_THR_LO 0
`define LSCR_ENC_CRC_BIT 7

// Interrupt status bits
`define LSCR_IRQ_LOCK_LOST 0
`define LSCR_IRQ_CRC_REJECT 1
`define LSCR_IRQ_FRAME_START 2
`define LSCR_IRQ_STRAP_DONE 3

// Timing
`define LSCR_CLK_PERIOD_NS 10
`define LSCR_STRAP_SETTLE_NS 160
`define LSCR_FILTER_WAIT_NS 320

`endif

// file: hdl/lscr_pkg.sv
package lscr_pkg;

    typedef enum logic [2:0] {
        LSCR_ST_FILL = 3'b001,
        LSCR_ST_SETTLE = 3'b010,
        LSCR_ST_DONE = 3'b100
    } lscr_strap_e;

    typedef logic [7:0] lscr_byte_t;

endpackage : lscr_pkg

// file: sim/lscr_regs_chk.sv
`timescale 1ns/1ns
module lscr_regs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lock_acquired,
    input wire logic parity_error,
    input wire logic clock_error,
    input wire logic control_error,
    input wire logic rx_lock,
    input wire logic pkt_valid,
    input wire logic pkt_crc_ok,
    input wire logic [7:0] pkt_info,
    input wire logic [7:0] link_info,
    input wire logic raw_mode,
    input wire logic frame_active_flag,
    input wire logic frame_start,
    input wire logic [6:0] gpio_output_mode,
    input wire logic [6:0] gpio_pulldown_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic any_err;
    logic raw_on;
    assign any_err = parity_error | clock_error | control_error;
    assign raw_on = raw_mode & frame_active_flag;
    wait_state_a: assert property (psel && !penable ##1 psel && penable
        |=> pready) else $error("no answer in second access cycle");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_with_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    lock_hold_a: assert property (
        !rx_lock && !lock_acquired |=> !rx_lock)
        else $error("lock came back without acquisition");
    lock_keep_a: assert property (
        rx_lock && !any_err |=> rx_lock) else $error("lock lost with no error");
    crc_pass_a: assert property (
        pkt_valid && pkt_crc_ok |=> link_info == $past(pkt_info))
        else $error("good packet not stored");
    info_hold_a: assert property (
        !pkt_valid |=> $stable(link_info)) else $error("info moved alone");
    frame_cause_a: assert property (
        frame_start |-> $past(raw_on)) else $error("frame start not raw");
    frame_once_a: assert property (
        frame_start |=> !frame_start) else $error("frame start too long");
    pulldown_off_a: assert property (
        (gpio_pulldown_en & $past(gpio_output_mode)) == 7'h00)
        else $error("pulldown on an output pin");
    strap_done_a: assert property (
        pready && !pwrite && paddr == 12'h2e0 |-> prdata[7] == prdata[3])
        else $error("strap done bits differ");
endmodule : lscr_regs_chk

bind lscr_regs lscr_regs_chk lscr_regs_chk_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_acquired(lock_acquired), .parity_error(parity_error),
    .clock_error(clock_error), .control_error(control_error),
    .rx_lock(rx_lock), .pkt_valid(pkt_valid), .pkt_crc_ok(pkt_crc_ok),
    .pkt_info(pkt_info), .link_info(link_info), .raw_mode(raw_mode),
    .frame_active_flag(frame_active_flag), .frame_start(frame_start),
    .gpio_output_mode(gpio_output_mode),
    .gpio_pulldown_en(gpio_pulldown_en));

// file: sim/lscr_link_model.sv
`timescale 1ns/1ns
module lscr_link_model (
    input wire logic pclk,
    output logic lock_acquired,
    output logic filter_update,
    output logic [2:0] fault,
    output logic pkt_valid,
    output logic pkt_crc_ok,
    output logic [7:0] pkt_info
);
    initial begin
        {lock_acquired, filter_update, fault, pkt_valid, pkt_crc_ok} = '0;
        pkt_info = 8'h00;
    end
    // Kind 0 lock, 1 filter update, 2..4 one fault each, 5 packet
    task automatic pulse(input int k, input logic [7:0] d, input logic ok);
        @(posedge pclk);
        lock_acquired <= (k == 0);
        filter_update <= (k == 1);
        fault <= 3'((k > 1 && k < 5) ? 1 << (k - 2) : 0);
        pkt_valid <= (k == 5);
        pkt_crc_ok <= ok;
        pkt_info <= d;
        @(posedge pclk);
        {lock_acquired, filter_update, fault, pkt_valid} <= '0;
        pkt_crc_ok <= ~ok;
        pkt_info <= ~d;
    endtask : pulse
endmodule : lscr_link_model

// file: sim/link_status_config_regs_bench.sv
`timescale 1ns/1ns
module link_status_config_regs_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, irq, rx_lock, frame_start, e, lk_acq, fup, pv, pok;
    logic raw_mode = 0, frame_flag = 0;
    logic [2:0] s_index, s_mode, fault;
    logic [6:0] gmode = 7'h00, pd_en;
    logic [7:0] pinfo, linfo, mdl ['hb6:'hc1];
    int n_mismatch = 0, n_compared = 0, seed = 32'h1e37, k, j, n;
    always #5 pclk = ~pclk;
    lscr_regs #(.STRAP_SETTLE_CYCLES(2), .FILTER_WAIT_CYCLES(4)) lscr_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .strap_index_pin(s_index), .strap_mode_pin(s_mode),
        .lock_acquired(lk_acq), .filter_update(fup),
        .parity_error(fault[0]), .clock_error(fault[1]),
        .control_error(fault[2]), .rx_lock(rx_lock), .pkt_valid(pv),
        .pkt_crc_ok(pok), .pkt_info(pinfo), .link_info(linfo),
        .raw_mode(raw_mode), .frame_active_flag(frame_flag),
        .frame_start(frame_start), .gpio_output_mode(gmode),
        .gpio_pulldown_en(pd_en));
    lscr_link_model lscr_link_model_i (.pclk(pclk), .lock_acquired(lk_acq),
        .filter_update(fup), .fault(fault), .pkt_valid(pv),
        .pkt_crc_ok(pok), .pkt_info(pinfo));
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    function automatic logic [7:0] wm(input int i);
        case (i)
            'hb8, 'hc0: return 8'h00;
            'hb9: return 8'h3f;
            'hbe: return 8'h7f;
            'hc1: return 8'h0f;
            default: return 8'hff;
        endcase
    endfunction : wm
    task automatic apb(input logic w, input int i, input logic [7:0] d);
        int t;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= 12'(i * 4);
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && e === 1'b0 && i >= 'hb6 && i <= 'hc1) begin
            mdl[i] = mdl[i] & ~wm(i) | d & wm(i);
        end
    endtask : apb
    task automatic rd(input int i, input logic [7:0] v);
        apb(0, i, 8'h00);
        chk(r, {24'h0, v});
    endtask : rd
    task automatic lk(input int k, input logic [7:0] d = 8'h00,
        input logic ok = 1'b0);
        lscr_link_model_i.pulse(k, d, ok);
    endtask : lk
    initial begin
        s_index = 3'($random(seed));
        s_mode = 3'($random(seed));
        mdl = '{8'h18, 8'h00, 8'h00, 8'h33, 8'h83, 8'h74, 8'h80, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00};
        repeat (20) @(posedge pclk);
        presetn <= 1;
        for (k = 'hb6; k <= 'hc1; k++) begin
            if (k != 'hb8 && k != 'hc0) rd(k, mdl[k]);
        end
        mdl['hb8] = {1'b1, s_index, 1'b1, s_mode};
        rd('hb8, mdl['hb8]);
        for (k = 'hb6; k <= 'hc1; k++) begin
            if (k != 'hc0) apb(1, k, 8'($random(seed)));
            if (k != 'hc0) rd(k, mdl[k]);
        end
        apb(1, 'h10, 8'h5a);
        chk(32'(e), 32'h1);
        rd('h10, 8'h00);
        chk(32'(e), 32'h1);
        $display("registers done");
        repeat (3) begin
            apb(1, 'hbe, 8'($random(seed)));
            gmode <= 7'($random(seed));
            repeat (2) @(negedge pclk);
            chk(pd_en, 7'(~gmode & ~mdl['hbe][6:0]));
        end
        for (k = 0; k < 6; k++) begin
            apb(1, 'hb9, (k == 5) ? 8'h05 : 8'h10 | 8'(k));
            n = (k == 5 || k == 0) ? 1 : k;
            lk(0);
            @(negedge pclk);
            chk(rx_lock, 1);
            for (j = 1; j <= n; j++) begin
                lk(2 + j % 3);
                @(negedge pclk);
                chk(rx_lock, j < n);
            end
        end
        for (k = 0; k < 2; k++) begin
            apb(1, 'hb9, k ? 8'h00 : 8'h20);
            lk(0);
            lk(1);
            lk(2);
            @(negedge pclk);
            chk(rx_lock, k == 0);
        end
        $display("link errors done");
        apb(1, 'hc1, 8'h02);
        apb(1, 'hba, 8'h83);
        apb(0, 'hc0, 8'h00);
        lk(5, 8'h3c, 1);
        lk(5, 8'hc5, 0);
        repeat (2) @(negedge pclk);
        chk(linfo, 8'h3c);
        chk(irq, 1);
        rd('hc0, 8'h02);
        repeat (2) @(negedge pclk);
        chk(irq, 0);
        apb(1, 'hba, 8'h03);
        apb(1, 'hc1, 8'h00);
        lk(5, 8'h96, 0);
        repeat (2) @(negedge pclk);
        chk(linfo, 8'h96);
        chk(irq, 0);
        $display("packets done");
        n = 1 + {$random(seed)} % 30;
        apb(1, 'hbc, 8'(n));
        @(posedge pclk);
        raw_mode <= 1;
        frame_flag <= 1;
        for (j = 0; j < 300 && frame_start !== 1'b1; j++) @(negedge pclk);
        chk(j, n + 2);
        if (j >= 300) complete_run();
        @(posedge pclk);
        frame_flag <= 0;
        raw_mode <= 0;
        @(posedge pclk);
        frame_flag <= 1;
        j = 0;
        repeat (40) begin
            @(negedge pclk);
            j += frame_start;
        end
        chk(j, 0);
        $display("frame start done");
        complete_run();
    end
endmodule : link_status_config_regs_bench
